//--- flash_guard_defs.svh
// Purpose: offsets, field positions, reset values and map limits of the flash guard
// Assumes: included by bare name from the two design modules, not the package
// Notes: definitions only
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

// register addresses on the plain register port
`define FLASH_CONTROL_ADDR 16'h0fff
`define GUARD_STATUS_ADDR 16'h0ffe

// flash_control field layout
`define KEY_MSB 7
`define KEY_LSB 4
`define BANK_BIT 3
`define FLASH_CONTROL_RESET 8'hc8
`define KEY_ARMED 4'h3
`define KEY_DISARMED 4'hc
`define BANK_RESET 1'b1

// guard_status field layout
`define ST_ARMED_BIT 0
`define ST_BLOCKED_BIT 1
`define ST_UNMAPPED_BIT 2
`define ST_BANK_BIT 3
`define ST_MODE_LSB 4
`define ST_MODE_MSB 6

// flash array and cpu address map
`define FLASH_BYTES 61440
`define FLASH_LO 16'h1000
`define FLASH_HI 16'hffff
`define ROM_LO 16'h7800
`define ROM_HI 16'h7fff
`define LOWER_FLASH_BANK_CPU_LO 16'h9000
`define UPPER_FLASH_BANK_CPU_LO 16'h8000
`define CPU_HI 16'hffff
`define ROM_ADDR_BITS 11
`define AREA_BITS 4
`define OFFSET_BITS 12

`endif

//--- flash_guard_pkg.sv
// Purpose: types shared by the flash guard modules
// Assumes: flash_guard_defs.svh holds the numbers
// Notes: one-hot codes written out
package flash_guard_pkg;

	// operating mode of the device, driven by the mode logic outside
	typedef enum logic [2:0]
	{
		mode_normal = 3'b001,
		mode_serial = 3'b010,
		mode_parallel = 3'b100
	} op_mode_t;

	// where a cpu access lands
	typedef enum logic [2:0]
	{
		route_none = 3'b001,
		route_flash = 3'b010,
		route_rom = 3'b100
	} route_t;

	// inclusive range check, used by several decoders
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
	begin
		in_range = (a >= lo) && (a <= hi);
	end
	endfunction

endpackage

//--- flash_addr_map.sv
// Purpose: translate a cpu address into a flash, boot rom or no target
// Assumes: mode and bank select are stable around the access
// Notes: purely combinational, registered by the caller
`timescale 1ns/100ps
`include "flash_guard_defs.svh"

module flash_addr_map
(
	input wire flash_guard_pkg::op_mode_t mode,
	input wire logic bank_sel,
	input wire logic [15:0] cpu_addr,
	output flash_guard_pkg::route_t route,
	output logic [15:0] flash_addr,
	output logic [`ROM_ADDR_BITS-1:0] rom_addr
);
	import flash_guard_pkg::*;

	wire logic hit_normal;
	wire logic hit_rom;
	wire logic hit_lower_flash_bank;
	wire logic hit_upper_flash_bank;
	wire logic [15:0] lower_flash_bank_addr;

	// range decodes for each mode and bank
	assign hit_normal = in_range(cpu_addr, `FLASH_LO, `FLASH_HI);
	assign hit_rom = in_range(cpu_addr, `ROM_LO, `ROM_HI);
	// 8000h-8fffh stays unrouted under bank 0, it has no flash behind it
	assign hit_lower_flash_bank = in_range(cpu_addr, `LOWER_FLASH_BANK_CPU_LO, `CPU_HI);
	assign hit_upper_flash_bank = in_range(cpu_addr, `UPPER_FLASH_BANK_CPU_LO, `CPU_HI);
	// bank 0 folds 9000h-ffffh down onto 1000h-7fffh
	assign lower_flash_bank_addr = {1'b0, cpu_addr[14:0]};

	// route selection, bank select only matters in serial mode
	always_comb
	begin
		route = route_none;
		flash_addr = cpu_addr;
		rom_addr = cpu_addr[`ROM_ADDR_BITS-1:0];
		unique case (mode)
			mode_normal:
			begin
				if (hit_normal)
					route = route_flash;
			end
			mode_serial:
			begin
				if (hit_rom)
					route = route_rom;
				else if (!bank_sel && hit_lower_flash_bank)
				begin
					route = route_flash;
					flash_addr = lower_flash_bank_addr;
				end
				else if (bank_sel && hit_upper_flash_bank)
					route = route_flash;
			end
			mode_parallel:
			begin
				// pins drive the array directly in this mode
				route = route_none;
			end
			default:
			begin
				route = route_none;
			end
		endcase
	end

endmodule

//--- flash_write_guard_bank_map.sv
// Purpose: flash control register, write guard and cpu-to-flash bank mapping
// Assumes: cpu strobes are one cycle, synchronous to mclk; mode comes from outside
// Notes: every access is answered one cycle after its strobe
//   guard_status at 0ffeh: bit 0 armed, 1 blocked, 2 unmapped, 3 bank, 6..4 mode
//   writing 1 to status bit 1 or 2 clears it; an event in that cycle wins
//   reserved key codes are stored and read back, but never open the guard
//   boot rom is read only, so a write there is reported as unmapped
//   control bits 2..0 and status bit 7 read as zero
//   mode is a plain input; the caller keeps it steady around each access
//   cmd_armed, strobes and pulses are flop outputs, one cycle behind the cause
//   a closed guard drops the write whole: no strobe, no address or data update
//
// What this block does
// - flash writes pass only while the command key holds 0011b.
// - writing 1100b to the key blocks all program and erase writes.
// - reset loads the key with 1100b, so the flash starts guarded.
// - control register resets to 1100 1 in bits 7..3; key 7..4, bank 3.
// - control register bits 2..0 read as undefined; this block returns zero.
// - bank bit picks bank 0 or 1, readable, effective in serial mode only.
// - normal mode maps flash at 1000h-ffffh and ignores the bank bit.
// - serial mode puts the 2 kbyte boot rom at 7800h-7fffh.
// - serial bank 0 maps cpu 9000h-ffffh onto flash 1000h-7fffh.
// - serial bank 1 maps cpu 8000h-ffffh straight onto flash 8000h-ffffh.
// - flash holds 61440 bytes at 1000h-ffffh.
// - the register governs flash only in normal and serial modes.
// - in serial mode the cpu drives flash, the host talks over the uart.
// - command writes carry a 12 bit offset and a 4 bit area select.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "flash_guard_defs.svh"

module flash_write_guard_bank_map
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire flash_guard_pkg::op_mode_t mode,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_wdata,
	output logic flash_rd,
	output logic flash_wr,
	output logic [`AREA_BITS-1:0] cmd_area,
	output logic [`OFFSET_BITS-1:0] cmd_offset,
	output logic [`ROM_ADDR_BITS-1:0] rom_addr,
	output logic rom_rd,
	output logic wr_blocked,
	output logic access_unmapped,
	output logic cmd_armed
);
	import flash_guard_pkg::*;

	// address match of one register on the plain port
	function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] where);
	begin
		reg_hit = (a == where);
	end
	endfunction

	// only the exact arming code opens the guard, reserved codes stay closed
	function automatic logic key_opens(input logic [3:0] key);
	begin
		key_opens = (key == `KEY_ARMED);
	end
	endfunction

	// control register state
	logic [3:0] key_q;
	logic bank_q;
	wire logic [3:0] key_d;
	wire logic bank_d;

	// sticky status flags: bit 0 blocked write, bit 1 unmapped access
	logic [1:0] sticky_q;
	logic [1:0] sticky_d;
	wire logic [1:0] sticky_set;
	wire logic [1:0] sticky_clr;

	// register read path
	logic [7:0] rdata_q;
	wire logic [7:0] rdata_d;
	wire logic [7:0] control_view;
	wire logic [7:0] status_view;

	// address decode of the register port
	wire logic sel_control;
	wire logic sel_status;
	wire logic wr_control;
	wire logic wr_status;

	// mapper results
	route_t route;
	wire logic [15:0] map_flash_addr;
	wire logic [`ROM_ADDR_BITS-1:0] map_rom_addr;

	// access qualification
	wire logic armed;
	wire logic to_flash;
	wire logic to_rom;
	wire logic to_none;
	wire logic flash_rd_d;
	wire logic flash_wr_d;
	wire logic rom_rd_d;
	wire logic blocked_d;
	wire logic unmapped_d;
	wire logic wr_to_flash;
	wire logic rd_unmapped;
	wire logic wr_unmapped;
	wire logic wr_to_rom;
	wire logic [`AREA_BITS-1:0] cmd_area_d;
	wire logic [`OFFSET_BITS-1:0] cmd_offset_d;

	// output flops
	logic [15:0] flash_addr_q;
	logic [7:0] flash_wdata_q;
	logic flash_rd_q;
	logic flash_wr_q;
	logic [`AREA_BITS-1:0] cmd_area_q;
	logic [`OFFSET_BITS-1:0] cmd_offset_q;
	logic [`ROM_ADDR_BITS-1:0] rom_addr_q;
	logic rom_rd_q;
	logic wr_blocked_q;
	logic unmapped_q;
	logic armed_q;

	// cpu address translation
	flash_addr_map i_flash_addr_map
	(
		.mode(mode),
		.bank_sel(bank_q),
		.cpu_addr(cpu_addr),
		.route(route),
		.flash_addr(map_flash_addr),
		.rom_addr(map_rom_addr)
	);

	// register port decode, anything else is unmapped and reads zero
	assign sel_control = reg_hit(reg_addr, `FLASH_CONTROL_ADDR);
	assign sel_status = reg_hit(reg_addr, `GUARD_STATUS_ADDR);
	assign wr_control = reg_wr && sel_control;
	assign wr_status = reg_wr && sel_status;

	// next control value; the key is kept as written so a reserved code reads back
	assign key_d = reg_wdata[`KEY_MSB:`KEY_LSB];
	assign bank_d = reg_wdata[`BANK_BIT];

	// the guard follows the stored key at once
	assign armed = key_opens(key_q);

	// route flags from the mapper
	assign to_flash = (route == route_flash);
	assign to_rom = (route == route_rom);
	assign to_none = (route == route_none);

	// qualified strobes toward the array and the boot rom
	assign wr_to_flash = cpu_wr && to_flash;
	assign flash_rd_d = cpu_rd && to_flash;
	assign flash_wr_d = wr_to_flash && armed;
	assign rom_rd_d = cpu_rd && to_rom;
	// a disarmed write to flash is swallowed and reported
	assign blocked_d = wr_to_flash && !armed;
	// every reason an access finds no target; boot rom is read only
	assign rd_unmapped = cpu_rd && to_none;
	assign wr_unmapped = cpu_wr && to_none;
	assign wr_to_rom = cpu_wr && to_rom;
	assign unmapped_d = rd_unmapped || wr_unmapped || wr_to_rom;

	// command area from the translated address, offset from the cpu's low bits
	assign cmd_area_d = map_flash_addr[15:`OFFSET_BITS];
	assign cmd_offset_d = cpu_addr[`OFFSET_BITS-1:0];

	// sticky flags: hardware set wins over software clear in the same cycle
	assign sticky_set = {unmapped_d, blocked_d};
	assign sticky_clr = wr_status ?
		{reg_wdata[`ST_UNMAPPED_BIT], reg_wdata[`ST_BLOCKED_BIT]} : 2'h0;

	// per-flag next state
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_sticky
			always_comb
			begin
				sticky_d[gi] = sticky_set[gi] | (sticky_q[gi] & ~sticky_clr[gi]);
			end
		end
	endgenerate

	// read views; low control bits are undefined, returned as zero here
	assign control_view = {key_q, bank_q, 3'h0};
	assign status_view = {1'b0, mode, bank_q, sticky_q, armed};

	// read data mux, valid in the cycle after the read strobe
	assign rdata_d = !reg_rd ? 8'h00 :
		sel_control ? control_view :
		sel_status ? status_view : 8'h00;

	// control register, reset disarms the guard
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			key_q <= `KEY_DISARMED;
			bank_q <= `BANK_RESET;
		end
		else if (wr_control)
		begin
			key_q <= key_d;
			bank_q <= bank_d;
		end
	end

	// sticky status flags
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sticky_q <= 2'h0;
		else
			sticky_q <= sticky_d;
	end

	// register read data
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end

	// flash read strobe, one cycle long
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			flash_rd_q <= 1'b0;
		else
			flash_rd_q <= flash_rd_d;
	end

	// flash write strobe, never raised while the guard is closed
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			flash_wr_q <= 1'b0;
		else
			flash_wr_q <= flash_wr_d;
	end

	// boot rom read strobe, one cycle long
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rom_rd_q <= 1'b0;
		else
			rom_rd_q <= rom_rd_d;
	end

	// refused write pulse
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			wr_blocked_q <= 1'b0;
		else
			wr_blocked_q <= blocked_d;
	end

	// unmapped access pulse
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			unmapped_q <= 1'b0;
		else
			unmapped_q <= unmapped_d;
	end

	// armed level, one cycle behind the key so the pin is a clean flop output
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			armed_q <= 1'b0;
		else
			armed_q <= armed;
	end

	// address and data, held between accesses so the array sees stable lines
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flash_addr_q <= 16'h0000;
			flash_wdata_q <= 8'h00;
		end
		else if (flash_rd_d || flash_wr_d)
		begin
			flash_addr_q <= map_flash_addr;
			flash_wdata_q <= cpu_wdata;
		end
	end

	// command area and offset of the last flash access that went through
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmd_area_q <= 4'h0;
			cmd_offset_q <= 12'h000;
		end
		else if (flash_rd_d || flash_wr_d)
		begin
			cmd_area_q <= cmd_area_d;
			cmd_offset_q <= cmd_offset_d;
		end
	end

	// boot rom address
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rom_addr_q <= 11'h000;
		else if (rom_rd_d)
			rom_addr_q <= map_rom_addr;
	end

	// outputs straight from flops
	assign reg_rdata = rdata_q;
	assign flash_addr = flash_addr_q;
	assign flash_wdata = flash_wdata_q;
	assign flash_rd = flash_rd_q;
	assign flash_wr = flash_wr_q;
	assign cmd_area = cmd_area_q;
	assign cmd_offset = cmd_offset_q;
	assign rom_addr = rom_addr_q;
	assign rom_rd = rom_rd_q;
	assign wr_blocked = wr_blocked_q;
	assign access_unmapped = unmapped_q;
	assign cmd_armed = armed_q;

endmodule

//--- flash_guard_properties.sv
// Purpose: port checks for the flash guard
// Assumes: cpu strobes answered one cycle later
// Notes: bound onto the design after the module
`timescale 1ns/100ps
module flash_guard_properties
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire flash_guard_pkg::op_mode_t mode,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [15:0] flash_addr,
	input wire logic flash_rd,
	input wire logic flash_wr,
	input wire logic [3:0] cmd_area,
	input wire logic [11:0] cmd_offset,
	input wire logic [10:0] rom_addr,
	input wire logic rom_rd,
	input wire logic wr_blocked,
	input wire logic access_unmapped,
	input wire logic cmd_armed
);
	import flash_guard_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// a lone cpu read taken in mode m while the address test ok holds
	sequence s_rd(m, ok);
		cpu_rd && !cpu_wr && mode == m && ok;
	endsequence
	a_write_armed: assert property (flash_wr |-> cmd_armed && $past(cpu_wr))
		else $error("flash write while disarmed");
	a_block_pulse: assert property (wr_blocked |-> !flash_wr && !cmd_armed)
		else $error("blocked write leaked");
	a_normal_direct: assert property (s_rd(mode_normal, cpu_addr >= 16'h1000)
		|=> flash_rd && flash_addr == $past(cpu_addr)) else $error("normal read moved");
	a_normal_low: assert property (s_rd(mode_normal, cpu_addr < 16'h1000)
		|=> access_unmapped && !flash_rd) else $error("low read routed");
	a_rom_window: assert property (s_rd(mode_serial, cpu_addr[15:11] == 5'h0f)
		|=> rom_rd && {5'h00, rom_addr} == ($past(cpu_addr) & 16'h07ff))
		else $error("rom miss");
	a_bank_fold: assert property (s_rd(mode_serial, cpu_addr[15:12] >= 4'h9)
		|=> flash_rd && (flash_addr & 16'h7fff) == ($past(cpu_addr) & 16'h7fff))
		else $error("bank fold");
	a_gap_split: assert property (s_rd(mode_serial, cpu_addr[15:12] == 4'h8)
		|=> (flash_rd ? flash_addr == $past(cpu_addr) : access_unmapped))
		else $error("8xxx routing");
	a_parallel_none: assert property (s_rd(mode_parallel, 1'b1)
		|=> access_unmapped && !flash_rd && !rom_rd) else $error("parallel routed");
	a_area_offset: assert property (flash_rd
		|-> cmd_area == flash_addr[15:12] && {4'h0, cmd_offset} == ($past(cpu_addr) & 16'h0fff))
		else $error("area or offset wrong");
endmodule
bind flash_write_guard_bank_map flash_guard_properties i_flash_guard_properties (.mclk,
	.arst_n, .mode, .cpu_addr, .cpu_rd, .cpu_wr, .flash_addr, .flash_rd, .flash_wr,
	.cmd_area, .cmd_offset, .rom_addr, .rom_rd, .wr_blocked, .access_unmapped, .cmd_armed);

//--- flash_array_model.sv
// Purpose: flash array beside the guard
// Assumes: one write pulse per byte
// Notes: keeps only the last byte, enough to see data arrive
`timescale 1ns/100ps
module flash_array_model
(
	input wire logic mclk,
	input wire logic [15:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	input wire logic flash_wr,
	output logic [7:0] last_byte,
	output logic stray_wr
);
	// no array below 1000h, so such a write is flagged
	always_ff @(posedge mclk)
	begin
		if (flash_wr)
		begin
			last_byte <= flash_wdata;
			stray_wr <= flash_addr < 16'h1000;
		end
	end
endmodule

//--- flash_write_guard_bank_map_test.sv
// Purpose: register and cpu access tests of the guard
// Assumes: answers one cycle after each strobe
// Notes: fixed waits only, as the answer time is fixed
`timescale 1ns/100ps
module flash_write_guard_bank_map_test;
	import flash_guard_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	op_mode_t mode = mode_normal;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0] cpu_wdata = 8'h00;
	logic cpu_rd = 1'b0;
	logic cpu_wr = 1'b0;
	logic [7:0] reg_rdata, flash_wdata, last_byte;
	logic [15:0] flash_addr;
	logic flash_rd, flash_wr, rom_rd, wr_blocked, access_unmapped, cmd_armed, stray_wr;
	logic [3:0] cmd_area;
	logic [11:0] cmd_offset;
	logic [10:0] rom_addr;
	int n_errors = 0;
	int comparisons = 0;
	always #25 mclk = ~mclk;
	flash_write_guard_bank_map i_flash_write_guard_bank_map (.mclk, .arst_n, .mode,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr, .cpu_wdata,
		.cpu_rd, .cpu_wr, .flash_addr, .flash_wdata, .flash_rd, .flash_wr, .cmd_area,
		.cmd_offset, .rom_addr, .rom_rd, .wr_blocked, .access_unmapped, .cmd_armed);
	flash_array_model i_flash_array_model (.mclk, .flash_addr, .flash_wdata, .flash_wr,
		.last_byte, .stray_wr);
	task automatic close_out;
	begin
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
	begin
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	end
	endtask
	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
	begin
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	end
	endtask
	// control reads pass m = f8h to mask off bits 2..0, their value is not promised
	task automatic reg_read(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
	begin
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, e & m}, {8'h00, reg_rdata & m});
	end
	endtask
	// one cpu access; k lists flash, rom, unmapped, blocked pulses
	task automatic acc(input logic w, input op_mode_t m, input logic [15:0] a,
		input logic [3:0] k, input logic [15:0] e);
	begin
		@(posedge mclk);
		mode <= m;
		cpu_addr <= a;
		cpu_wdata <= a[7:0] ^ 8'h5a;
		cpu_wr <= w;
		cpu_rd <= !w;
		@(posedge mclk);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		#1 chk("pulses", {12'h000, k},
			{12'h000, flash_rd | flash_wr, rom_rd, access_unmapped, wr_blocked});
		if (k[3])
			chk("flash_addr", e, flash_addr);
		if (k[3])
			chk("flash_wr", {15'h0000, w}, {15'h0000, flash_wr});
		if (k[2])
			chk("rom_addr", e, {5'h00, rom_addr});
		if (k[3] && w)
			chk("flash_wdata", {8'h00, a[7:0] ^ 8'h5a}, {8'h00, flash_wdata});
	end
	endtask
	initial
	begin
		#200000;
		n_errors++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		reg_read(16'h0fff, 8'hf8, 8'hc8);
		chk("cmd_armed", 16'h0000, {15'h0000, cmd_armed});
		reg_read(16'h0123, 8'hff, 8'h00);
		acc(1, mode_normal, 16'h2000, 4'h1, 16'h0000);
		reg_write(16'h0fff, 8'h30);
		reg_read(16'h0fff, 8'hf8, 8'h30);
		chk("cmd_armed", 16'h0001, {15'h0000, cmd_armed});
		acc(1, mode_normal, 16'h2034, 4'h8, 16'h2034);
		chk("cmd_area", 16'h0002, {12'h000, cmd_area});
		chk("cmd_offset", 16'h0034, {4'h0, cmd_offset});
		acc(0, mode_normal, 16'h9000, 4'h8, 16'h9000);
		chk("last_byte", 16'h006e, {8'h00, last_byte});
		acc(0, mode_normal, 16'h0fff, 4'h2, 16'h0000);
		acc(0, mode_serial, 16'hf000, 4'h8, 16'h7000);
		chk("cmd_area", 16'h0007, {12'h000, cmd_area});
		acc(0, mode_serial, 16'h8800, 4'h2, 16'h0000);
		acc(0, mode_serial, 16'h7800, 4'h4, 16'h0000);
		acc(0, mode_serial, 16'h7fff, 4'h4, 16'h07ff);
		acc(0, mode_serial, 16'h77ff, 4'h2, 16'h0000);
		acc(1, mode_serial, 16'h9abc, 4'h8, 16'h1abc);
		acc(1, mode_parallel, 16'h2000, 4'h2, 16'h0000);
		reg_write(16'h0fff, 8'h38);
		acc(0, mode_serial, 16'h8800, 4'h8, 16'h8800);
		acc(0, mode_serial, 16'h9000, 4'h8, 16'h9000);
		reg_write(16'h0fff, 8'h58);
		acc(1, mode_normal, 16'h3000, 4'h1, 16'h0000);
		reg_write(16'h0fff, 8'hc8);
		acc(1, mode_normal, 16'h3000, 4'h1, 16'h0000);
		reg_read(16'h0fff, 8'hf8, 8'hc8);
		reg_read(16'h0ffe, 8'hff, 8'h1e);
		reg_write(16'h0ffe, 8'h06);
		reg_read(16'h0ffe, 8'hff, 8'h18);
		fork
			reg_write(16'h0ffe, 8'h02);
			acc(1, mode_normal, 16'h3000, 4'h1, 16'h0000);
		join
		reg_read(16'h0ffe, 8'hff, 8'h1a);
		chk("stray_wr", 16'h0000, {15'h0000, stray_wr});
		close_out();
	end
endmodule
